/* File: core/rgfc_regs.vh */
`ifndef RGFC_REGS_VH
`define RGFC_REGS_VH

// Flag octet seen on the receive frame octet bus
`define RGFC_FLAG_OCTET 8'h7E
// Bits in one flow control nibble
`define RGFC_NIBBLE_BITS 4
// Reference clock period in ns
`define RGFC_CLK_PERIOD_NS 100
// Strobe high and low half periods in ns (least times)
`define RGFC_STROBE_HALF_NS 200
// Cycles per strobe half period, rounded up, at least one
`define RGFC_STROBE_HALF_CYC \
    ((`RGFC_STROBE_HALF_NS + `RGFC_CLK_PERIOD_NS - 1) / `RGFC_CLK_PERIOD_NS)
// Mode encodings
`define RGFC_MODE_ATM 1'b0
`define RGFC_MODE_HDLC 1'b1
// Reset level of all outputs
`define RGFC_OUT_RESET 1'b0

`endif

/* File: core/rgfc_chan.v */
`timescale 1ns/1ps
`include "rgfc_regs.vh"

// One channel of the flow control serial port and frame status sideband
module rgfc_chan #(
    parameter HALF_CYC = `RGFC_STROBE_HALF_CYC
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire mode_hdlc_i,
    input wire cell_valid_i,
    input wire [3:0] cell_flow_ctl_i,
    input wire [7:0] rx_frame_octet_bus_i,
    input wire frame_end_i,
    input wire frame_fcs_good_i,
    input wire frame_abort_i,
    output reg rx_flow_ctl_serial_out_o,
    output reg flow_ctl_port_strobe_o,
    output reg flow_ctl_msb_marker_o,
    output reg frame_check_ok_o,
    output wire busy_o
);
    localparam ST_IDLE = 2'b00;
    localparam ST_LOW = 2'b01;
    localparam ST_HIGH = 2'b10;

    reg [1:0] state;
    reg [3:0] shift;
    reg [2:0] bit_cnt;
    reg [7:0] half_cnt;
    reg pending;
    reg [3:0] pend_nib;

    assign busy_o = (state != ST_IDLE);

    // Serialiser: each bit is set up in LOW, strobe rises in HIGH
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            shift <= 4'h0;
            bit_cnt <= 3'h0;
            half_cnt <= 8'h00;
            pending <= 1'b0;
            pend_nib <= 4'h0;
            rx_flow_ctl_serial_out_o <= `RGFC_OUT_RESET;
            flow_ctl_port_strobe_o <= `RGFC_OUT_RESET;
            flow_ctl_msb_marker_o <= `RGFC_OUT_RESET;
            frame_check_ok_o <= `RGFC_OUT_RESET;
        end else if (mode_hdlc_i == `RGFC_MODE_HDLC) begin
            state <= ST_IDLE;
            pending <= 1'b0;
            flow_ctl_port_strobe_o <= 1'b0;
            flow_ctl_msb_marker_o <= 1'b0;
            rx_flow_ctl_serial_out_o <= frame_end_i | frame_abort_i |
                (rx_frame_octet_bus_i == `RGFC_FLAG_OCTET);
            frame_check_ok_o <= frame_end_i & frame_fcs_good_i & ~frame_abort_i;
        end else begin
            frame_check_ok_o <= 1'b0;
            // One nibble held while the current one shifts out
            if (cell_valid_i && (state != ST_IDLE || pending)) begin
                pending <= 1'b1;
                pend_nib <= cell_flow_ctl_i;
            end
            case (state)
                ST_IDLE: begin
                    flow_ctl_port_strobe_o <= 1'b0;
                    flow_ctl_msb_marker_o <= 1'b0;
                    if (pending || cell_valid_i) begin
                        shift <= pending ? pend_nib : cell_flow_ctl_i;
                        if (pending && !cell_valid_i) pending <= 1'b0;
                        bit_cnt <= 3'h0;
                        half_cnt <= 8'h00;
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // Strobe low while the next bit settles
                    flow_ctl_port_strobe_o <= 1'b0;
                    // MSB first on the serial pin
                    rx_flow_ctl_serial_out_o <= shift[3];
                    flow_ctl_msb_marker_o <= (bit_cnt == 3'h0);
                    if (half_cnt == HALF_CYC - 1) begin
                        half_cnt <= 8'h00;
                        state <= ST_HIGH;
                    end else begin
                        half_cnt <= half_cnt + 8'h01;
                    end
                end
                ST_HIGH: begin
                    flow_ctl_port_strobe_o <= 1'b1;
                    if (half_cnt == HALF_CYC - 1) begin
                        half_cnt <= 8'h00;
                        shift <= {shift[2:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'h1;
                        state <= (bit_cnt == `RGFC_NIBBLE_BITS - 1) ? ST_IDLE : ST_LOW;
                    end else begin
                        half_cnt <= half_cnt + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // rgfc_chan

/* File: core/rgfc_top.v */
`timescale 1ns/1ps
`include "rgfc_regs.vh"

module rgfc_top #(
    parameter CHANNELS = 3
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [CHANNELS-1:0] mode_hdlc_i,
    input wire [CHANNELS-1:0] cell_valid_i,
    input wire [4*CHANNELS-1:0] cell_flow_ctl_i,
    input wire [8*CHANNELS-1:0] rx_frame_octet_bus_i,
    input wire [CHANNELS-1:0] frame_end_i,
    input wire [CHANNELS-1:0] frame_fcs_good_i,
    input wire [CHANNELS-1:0] frame_abort_i,
    output wire [CHANNELS-1:0] rx_flag_idle_indicator_o,
    output wire [CHANNELS-1:0] rx_flow_ctl_serial_out_o,
    output wire [CHANNELS-1:0] flow_ctl_port_strobe_o,
    output wire [CHANNELS-1:0] flow_ctl_msb_marker_o,
    output wire [CHANNELS-1:0] frame_check_ok_o,
    output wire [CHANNELS-1:0] busy_o
);
    wire [CHANNELS-1:0] shared_pin;

    assign rx_flow_ctl_serial_out_o = shared_pin & ~mode_hdlc_i;
    assign rx_flag_idle_indicator_o = shared_pin & mode_hdlc_i;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
            rgfc_chan u_chan (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .mode_hdlc_i(mode_hdlc_i[g]),
                .cell_valid_i(cell_valid_i[g]),
                .cell_flow_ctl_i(cell_flow_ctl_i[4*g+3:4*g]),
                .rx_frame_octet_bus_i(rx_frame_octet_bus_i[8*g+7:8*g]),
                .frame_end_i(frame_end_i[g]),
                .frame_fcs_good_i(frame_fcs_good_i[g]),
                .frame_abort_i(frame_abort_i[g]),
                .rx_flow_ctl_serial_out_o(shared_pin[g]),
                .flow_ctl_port_strobe_o(flow_ctl_port_strobe_o[g]),
                .flow_ctl_msb_marker_o(flow_ctl_msb_marker_o[g]),
                .frame_check_ok_o(frame_check_ok_o[g]),
                .busy_o(busy_o[g])
            );
        end
    endgenerate
endmodule // rgfc_top

/* File: tb/rgfc_properties.sv */
`timescale 1ns/1ps
// Sideband port checks, one reference clock domain
module rgfc_props #(parameter CHANNELS = 3) (
    input ref_clk_i,
    input reset_i,
    input [CHANNELS-1:0] mode_hdlc_i,
    input [CHANNELS-1:0] cell_valid_i,
    input [8*CHANNELS-1:0] rx_frame_octet_bus_i,
    input [CHANNELS-1:0] frame_end_i,
    input [CHANNELS-1:0] frame_fcs_good_i,
    input [CHANNELS-1:0] frame_abort_i,
    input [CHANNELS-1:0] rx_flag_idle_indicator_o,
    input [CHANNELS-1:0] flow_ctl_port_strobe_o,
    input [CHANNELS-1:0] flow_ctl_msb_marker_o,
    input [CHANNELS-1:0] frame_check_ok_o,
    input [CHANNELS-1:0] busy_o
);
    // Short aliases
    wire [CHANNELS-1:0] md = mode_hdlc_i, idl = rx_flag_idle_indicator_o, ok = frame_check_ok_o;
    wire [CHANNELS-1:0] stb = flow_ctl_port_strobe_o, msb = flow_ctl_msb_marker_o;
    wire [CHANNELS-1:0] fe = frame_end_i, fg = frame_fcs_good_i, fa = frame_abort_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_strobe_mode: assert property ((md & $past(md) & (stb | msb)) == 0)
        else $error("strobe or marker active in HDLC");
    a_atm_idle: assert property ((~md & ~$past(md) & idl) == 0)
        else $error("idle active in ATM");
    a_flag_idle: assert property (md[1] && rx_frame_octet_bus_i[15:8] == 8'h7e |=> idl[1])
        else $error("idle missing on flag");
    a_good_frame: assert property (md[1] && fe[1] && fg[1] && !fa[1] |=> idl[1] && ok[1])
        else $error("good frame status wrong");
    a_bad_frame: assert property (md[1] && fe[1] && !fg[1] |=> idl[1] && !ok[1])
        else $error("bad frame status wrong");
    a_abort_code: assert property (md[1] && fa[1] |=> idl[1] && !ok[1])
        else $error("abort status wrong");
    a_marker_lead: assert property ($rose(msb[0]) |-> ##2 $rose(stb[0]))
        else $error("strobe not two cycles after marker");
    a_cell_start: assert property (!md[0] && cell_valid_i[0] && !busy_o[0] |-> ##2 $rose(msb[0]))
        else $error("nibble did not start");
    a_strobe_width: assert property ($rose(stb[0]) |=> stb[0] ##1 !stb[0])
        else $error("strobe high time wrong");
    c_nibble: cover property ($rose(msb[0]));
    c_good: cover property (md[1] && fe[1] && fg[1]);
    c_abort: cover property (md[1] && fa[1]);
endmodule // rgfc_props

bind rgfc_top rgfc_props #(.CHANNELS(CHANNELS)) u_props (.*);

/* File: tb/rgfc_sink.sv */
`timescale 1ns/1ps
// Far-side latch: shifts on strobe rise, restarts on marker
module rgfc_sink (
    input wire ref_clk_i,
    input wire data_i,
    input wire strobe_i,
    input wire marker_i,
    output logic [3:0] nibble_o = 0,
    output logic got_o = 0
);
    logic last = 0;
    int cnt = 0;
    always @(posedge ref_clk_i) begin
        got_o <= 0;
        last <= strobe_i;
        if (strobe_i && !last) begin
            cnt = marker_i ? 1 : cnt + 1;
            nibble_o <= {nibble_o[2:0], data_i};
            if (cnt == 4) got_o <= 1;
        end
    end
endmodule // rgfc_sink

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 0, reset_i = 1;
    logic [2:0] mode_hdlc_i = 3'b010, cell_valid_i = 0, frame_end_i = 0, frame_fcs_good_i = 0;
    logic [2:0] frame_abort_i = 0;
    logic [11:0] cell_flow_ctl_i = 0;
    logic [23:0] rx_frame_octet_bus_i = 0;
    wire [2:0] rx_flag_idle_indicator_o, rx_flow_ctl_serial_out_o, flow_ctl_port_strobe_o;
    wire [2:0] flow_ctl_msb_marker_o, frame_check_ok_o, busy_o;
    wire [3:0] nib;
    wire got;
    int bad_count = 0, checks = 0, seed = 32'h6704_ee18, k, n;
    logic [3:0] q[$];
    logic e_idle, e_ok;
    // Reference clock
    always #50 ref_clk_i = ~ref_clk_i;
    rgfc_top uut (.*);
    rgfc_sink sink (.ref_clk_i(ref_clk_i), .data_i(rx_flow_ctl_serial_out_o[0]),
        .strobe_i(flow_ctl_port_strobe_o[0]), .marker_i(flow_ctl_msb_marker_o[0]),
        .nibble_o(nib), .got_o(got));
    // Compare and count
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Channel 1 frame events, then channel 0 nibbles
    initial begin
        repeat (12) @(negedge ref_clk_i);
        reset_i = 0;
        for (k = 0; k < 16; k++) begin
            @(negedge ref_clk_i);
            n = $random(seed);
            rx_frame_octet_bus_i = {n[7:0], (k % 4 == 0) ? 8'h7e : n[15:8], 8'h7e};
            frame_end_i[1] = k % 4 == 1 || k % 4 == 2;
            frame_fcs_good_i[1] = k % 4 == 1;
            frame_abort_i[1] = k % 4 == 3;
            e_idle = rx_frame_octet_bus_i[15:8] == 8'h7e || frame_end_i[1] || frame_abort_i[1];
            e_ok = frame_end_i[1] && frame_fcs_good_i[1];
            @(negedge ref_clk_i);
            chk({rx_flag_idle_indicator_o[1], frame_check_ok_o[1], flow_ctl_port_strobe_o[1],
                rx_flag_idle_indicator_o[0]}, {e_idle, e_ok, 2'b00});
            frame_end_i = 0;
            frame_abort_i = 0;
        end
        for (k = 0; k < 6; k++) begin
            @(negedge ref_clk_i);
            cell_flow_ctl_i = $random(seed);
            cell_valid_i = 3'b101;
            q.push_back(cell_flow_ctl_i[3:0]);
            @(negedge ref_clk_i);
            cell_valid_i = 0;
            for (n = 0; n < 40 && !got; n++) @(negedge ref_clk_i);
            if (!got) begin
                bad_count++;
                test_done;
            end
            chk(nib, q.pop_front());
        end
        test_done;
    end
endmodule // tb
